// ---- design/rscd_decoder.sv ----
// Purpose: Decodes command bytes from the host SPI port into radio actions and memory accesses.
// Assumes: An SPI slave front end delivers each received byte with a one-cycle strobe and a frame level.
// Notes:   Memory data and read returns pass through as byte strobes; memories live outside.
`timescale 1ns/1ps
`include "rscd_defs.svh"

module rscd_decoder (
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_frame,
   input  wire logic                        i_byte_valid,
   input  wire logic [7:0]                  i_byte,
   input  wire logic [1:0]                  i_module,
   input  wire logic [7:0]                  i_rd_data,
   output rscd_pkg::rscd_radio_state_t      o_radio_state,
   output rscd_pkg::rscd_action_t           o_action,
   output logic                             o_action_valid,
   output logic                             o_synced,
   output logic                             o_core_reset,
   output logic [10:0]                      o_mem_addr,
   output logic [2:0]                       o_mem_region,
   output logic                             o_mem_wr,
   output logic [7:0]                       o_mem_wr_data,
   output logic                             o_mem_rd,
   output logic [7:0]                       o_tx_byte,
   output logic                             o_tx_byte_valid
);
   import rscd_pkg::*;

   typedef enum logic [2:0] {
      st_command,
      st_low_addr,
      st_seq_data,
      st_scat_addr,
      st_scat_data
   } rscd_phase_t;

   rscd_phase_t       phase;
   logic              is_write;
   logic              is_read;
   logic              is_scattered;
   logic              mem_start;
   logic              low_valid;
   logic              advance;
   logic              radio_req;
   rscd_radio_state_t radio_target;
   rscd_action_t      next_action;
   logic              full_reset;
   logic              cmd_byte;
   logic [4:0]        op;
   logic              region_ok;
   logic              rd_pending;
   logic              step_due;
   logic              next_rd;

   assign cmd_byte  = i_byte_valid && i_frame && phase == st_command;
   assign op        = i_byte[`RSCD_MEM_OP_MSB:`RSCD_MEM_OP_LSB];
   assign region_ok = i_byte[2:0] == `RSCD_REGION_PACKET || i_byte[2:0] == `RSCD_REGION_BATTERY
                      || i_byte[2:0] == `RSCD_REGION_MODEM;

   // Memory command decoding; unlisted regions fall through as ignored.
   always_comb begin
      mem_start = 1'b0;
      if (cmd_byte && o_synced) begin
         if (op == `RSCD_SEQ_WRITE_OP) begin
            mem_start = region_ok || i_byte[2:0] == `RSCD_REGION_PROGRAM;
         end else if (op == `RSCD_SEQ_READ_OP || op == `RSCD_SCATTERED_WRITE_OP
                      || op == `RSCD_SCATTERED_READ_OP) begin
            mem_start = region_ok;
         end
      end
   end

   // Radio-controller and module command decoding.
   always_comb begin
      radio_req    = 1'b0;
      radio_target = idle_state;
      next_action  = act_none;
      full_reset   = 1'b0;
      if (cmd_byte && o_synced) begin
         case (i_byte)
            `RSCD_GOTO_OFF_CMD: begin
               radio_req    = 1'b1;
               radio_target = off_state;
            end
            `RSCD_GOTO_IDLE_CMD: begin
               radio_req    = 1'b1;
               radio_target = idle_state;
            end
            `RSCD_GOTO_RECEIVE_CMD: begin
               radio_req    = 1'b1;
               radio_target = receive_state;
            end
            `RSCD_GOTO_TRANSMIT_CMD: begin
               radio_req    = 1'b1;
               radio_target = transmit_state;
            end
            `RSCD_GOTO_SLEEP_CMD: begin
               radio_req    = 1'b1;
               radio_target = sleep_state;
            end
            `RSCD_APPLY_CONFIG_CMD:    next_action = act_apply_config;
            `RSCD_SIGNAL_STRENGTH_CMD: next_action = act_signal_strength;
            `RSCD_IF_FILTER_CAL_CMD:   next_action = act_if_filter_cal;
            `RSCD_FULL_RESET_CMD:      full_reset  = 1'b1;
            `RSCD_LOAD_INIT_CMD:       next_action = act_load_init;
            `RSCD_LOAD_DONE_CMD:       next_action = act_load_done;
            `RSCD_IMAGE_CAL_CMD: begin
               if (i_module == `RSCD_MODULE_IMAGE_CAL) begin
                  next_action = act_image_cal;
               end
            end
            `RSCD_MODULE_CMD_A: begin
               if (i_module == `RSCD_MODULE_CIPHER) begin
                  next_action = act_cipher_encrypt;
               end else if (i_module == `RSCD_MODULE_FEC) begin
                  next_action = act_fec_encode;
               end
            end
            `RSCD_MODULE_CMD_B: begin
               if (i_module == `RSCD_MODULE_CIPHER) begin
                  next_action = act_cipher_decrypt_setup;
               end else if (i_module == `RSCD_MODULE_FEC) begin
                  next_action = act_fec_encode_setup;
               end
            end
            `RSCD_MODULE_CMD_C: begin
               if (i_module == `RSCD_MODULE_CIPHER) begin
                  next_action = act_cipher_decrypt;
               end else if (i_module == `RSCD_MODULE_FEC) begin
                  next_action = act_fec_decode;
               end
            end
            `RSCD_FILLER_CMD: next_action = act_none;
            default:          next_action = act_none;
         endcase
      end
   end

   // The controller accepts nothing but the sync byte until aligned; a full reset drops alignment.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_synced <= 1'b0;
      end else if (full_reset) begin
         o_synced <= 1'b0;
      end else if (cmd_byte && i_byte == `RSCD_SYNC_CMD) begin
         o_synced <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_action       <= act_none;
         o_action_valid <= 1'b0;
         o_core_reset   <= 1'b0;
      end else begin
         o_action       <= next_action;
         o_action_valid <= next_action != act_none;
         o_core_reset   <= next_action == act_load_done || full_reset;
      end
   end

   // Transaction phase; a dropped frame always returns to command decoding.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         phase        <= st_command;
         is_write     <= 1'b0;
         is_read      <= 1'b0;
         is_scattered <= 1'b0;
         o_mem_region <= 3'h0;
      end else if (!i_frame) begin
         phase <= st_command;
      end else if (i_byte_valid) begin
         case (phase)
            st_command: begin
               if (mem_start) begin
                  is_write     <= op == `RSCD_SEQ_WRITE_OP || op == `RSCD_SCATTERED_WRITE_OP;
                  is_read      <= op == `RSCD_SEQ_READ_OP || op == `RSCD_SCATTERED_READ_OP;
                  is_scattered <= op == `RSCD_SCATTERED_WRITE_OP || op == `RSCD_SCATTERED_READ_OP;
                  o_mem_region <= i_byte[2:0];
                  phase        <= st_low_addr;
               end
            end
            st_low_addr:  phase <= is_scattered ? st_scat_data : st_seq_data;
            st_seq_data:  phase <= st_seq_data;
            st_scat_data: phase <= st_scat_addr;
            st_scat_addr: phase <= st_scat_data;
            default:      phase <= st_command;
         endcase
      end
   end

   // Writes strobe on data bytes; reads fetch at each address and on every filler byte of a sequential read.
   always_comb begin
      low_valid = i_byte_valid && (phase == st_low_addr || phase == st_scat_addr);
      advance   = i_byte_valid && phase == st_seq_data;
      next_rd   = i_frame && is_read && (low_valid || step_due);
   end

   // The address steps one cycle after a data or filler byte, so each strobe sees the address it belongs to.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         step_due <= 1'b0;
      end else begin
         step_due <= advance && i_frame;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_wr      <= 1'b0;
         o_mem_wr_data <= 8'h00;
         o_mem_rd      <= 1'b0;
         rd_pending    <= 1'b0;
      end else begin
         o_mem_wr   <= i_frame && is_write && i_byte_valid
                       && (phase == st_seq_data || phase == st_scat_data);
         o_mem_rd   <= next_rd;
         rd_pending <= next_rd;
         if (i_byte_valid) begin
            o_mem_wr_data <= i_byte;
         end
      end
   end

   // Read data goes out one cycle after the fetch; sequential reads pre-fetch the next byte.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_byte       <= 8'h00;
         o_tx_byte_valid <= 1'b0;
      end else begin
         o_tx_byte_valid <= rd_pending;
         if (rd_pending) begin
            o_tx_byte <= i_rd_data;
         end
      end
   end

   rscd_mem_port u_mem_port (
      .i_ref_clk   (i_ref_clk),
      .i_rst       (i_rst),
      .i_start     (mem_start && i_frame),
      .i_high_addr (i_byte[2:0]),
      .i_low_valid (low_valid && i_frame),
      .i_low_addr  (i_byte),
      .i_advance   (step_due && i_frame),
      .o_addr      (o_mem_addr)
   );

   rscd_radio_state u_radio_state (
      .i_ref_clk    (i_ref_clk),
      .i_rst        (i_rst),
      .i_req        (radio_req),
      .i_target     (radio_target),
      .i_full_reset (full_reset),
      .o_state      (o_radio_state)
   );
endmodule

// ---- inc/rscd_defs.svh ----
// Purpose: Command codes and field positions for the radio SPI command decoder.
// Assumes: Byte-wide command stream from an SPI slave front end.
// Notes:   Command, op, region and module codes live here; the region field bits [2:0] are written inline.
`ifndef RSCD_DEFS_SVH
`define RSCD_DEFS_SVH

`define RSCD_SYNC_CMD              8'ha2
`define RSCD_GOTO_OFF_CMD          8'hb0
`define RSCD_GOTO_IDLE_CMD         8'hb1
`define RSCD_GOTO_RECEIVE_CMD      8'hb2
`define RSCD_GOTO_TRANSMIT_CMD     8'hb5
`define RSCD_GOTO_SLEEP_CMD        8'hba
`define RSCD_APPLY_CONFIG_CMD      8'hbb
`define RSCD_SIGNAL_STRENGTH_CMD   8'hbc
`define RSCD_IMAGE_CAL_CMD         8'hbd
`define RSCD_IF_FILTER_CAL_CMD     8'hbe
`define RSCD_LOAD_INIT_CMD         8'hbf
`define RSCD_LOAD_DONE_CMD         8'hc7
`define RSCD_FULL_RESET_CMD        8'hc8
`define RSCD_MODULE_CMD_A          8'hd0
`define RSCD_MODULE_CMD_B          8'hd1
`define RSCD_MODULE_CMD_C          8'hd2
`define RSCD_FILLER_CMD            8'hff

`define RSCD_MEM_OP_MSB            7
`define RSCD_MEM_OP_LSB            3
`define RSCD_SEQ_WRITE_OP          5'h03
`define RSCD_SEQ_READ_OP           5'h07
`define RSCD_SCATTERED_WRITE_OP    5'h01
`define RSCD_SCATTERED_READ_OP     5'h05
`define RSCD_REGION_PACKET         3'h0
`define RSCD_REGION_BATTERY        3'h1
`define RSCD_REGION_MODEM          3'h3
`define RSCD_REGION_PROGRAM        3'h6

`define RSCD_MODULE_NONE           2'h0
`define RSCD_MODULE_IMAGE_CAL      2'h1
`define RSCD_MODULE_CIPHER         2'h2
`define RSCD_MODULE_FEC            2'h3

`endif

// ---- inc/rscd_pkg.sv ----
// Purpose: Types shared by the radio SPI command decoder.
// Assumes: Constants come from rscd_defs.svh.
// Notes:   Holds only types.
package rscd_pkg;
   typedef enum logic [2:0] {
      off_state,
      idle_state,
      receive_state,
      transmit_state,
      sleep_state
   } rscd_radio_state_t;

   typedef enum logic [3:0] {
      act_none,
      act_apply_config,
      act_signal_strength,
      act_if_filter_cal,
      act_image_cal,
      act_cipher_encrypt,
      act_cipher_decrypt_setup,
      act_cipher_decrypt,
      act_fec_encode_setup,
      act_fec_encode,
      act_fec_decode,
      act_load_init,
      act_load_done
   } rscd_action_t;
endpackage

// ---- design/rscd_radio_state.sv ----
// Purpose: Radio state holder driven by decoded transition requests.
// Assumes: Requests are one-cycle pulses on the decoder clock.
// Notes:   Power-on and full reset both leave the radio asleep.
`timescale 1ns/1ps
module rscd_radio_state (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rst,
   input  wire logic                       i_req,
   input  wire rscd_pkg::rscd_radio_state_t i_target,
   input  wire logic                       i_full_reset,
   output rscd_pkg::rscd_radio_state_t     o_state
);
   import rscd_pkg::*;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_state <= sleep_state;
      end else if (i_full_reset) begin
         o_state <= sleep_state;
      end else if (i_req) begin
         o_state <= i_target;
      end
   end
endmodule

// ---- design/rscd_mem_port.sv ----
// Purpose: Address generator for one memory access transaction.
// Assumes: Byte strobes come from the decoder on the same clock.
// Notes:   Upper address bits are loaded at the start; a step past a low byte of ff carries into them.
`timescale 1ns/1ps
module rscd_mem_port (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic [2:0]  i_high_addr,
   input  wire logic        i_low_valid,
   input  wire logic [7:0]  i_low_addr,
   input  wire logic        i_advance,
   output logic      [10:0] o_addr
);
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_addr <= 11'h000;
      end else if (i_start) begin
         o_addr <= {i_high_addr, 8'h00};
      end else if (i_low_valid) begin
         o_addr <= {o_addr[10:8], i_low_addr};
      end else if (i_advance) begin
         o_addr <= o_addr + 11'h001;
      end
   end
endmodule

// ---- dv/rscd_checker.sv ----
// Purpose: Concurrent checks on the ports of the radio SPI command decoder.
// Assumes: A byte is taken at a rising edge with strobe and frame both high.
// Notes:   Bound to every decoder instance at the foot of this file.
`timescale 1ns/1ps
module rscd_checker (
   input wire logic                        i_ref_clk,
   input wire logic                        i_rst,
   input wire logic                        i_frame,
   input wire logic                        i_byte_valid,
   input wire logic [7:0]                  i_byte,
   input wire logic [1:0]                  i_module,
   input wire logic [7:0]                  i_rd_data,
   input wire rscd_pkg::rscd_radio_state_t o_radio_state,
   input wire rscd_pkg::rscd_action_t      o_action,
   input wire logic                        o_action_valid,
   input wire logic                        o_synced,
   input wire logic                        o_core_reset,
   input wire logic                        o_mem_wr,
   input wire logic                        o_mem_rd,
   input wire logic [7:0]                  o_tx_byte,
   input wire logic                        o_tx_byte_valid
);
   import rscd_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic tk;
   logic sync_byte;
   logic in_cmd;
   logic tc;
   assign tk = i_frame && i_byte_valid;
   assign tc = tk && in_cmd;
   // Bytes inside a memory transfer are data, not commands, until the frame drops.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         in_cmd <= 1'b1;
      end else if (!i_frame) begin
         in_cmd <= 1'b1;
      end else if (tc && o_synced && i_byte inside {8'h18, 8'h19, 8'h1b, 8'h1e, 8'h38, 8'h39, 8'h3b,
                                                    8'h08, 8'h09, 8'h0b, 8'h28, 8'h29, 8'h2b}) begin
         in_cmd <= 1'b0;
      end
   end
   assign sync_byte = tk && (i_byte == 8'ha2);
   sequence s_ret;
      o_tx_byte_valid ##0 (o_tx_byte == $past(i_rd_data));
   endsequence
   property p_sync;
      $rose(o_synced) |-> $past(sync_byte);
   endproperty
   a_sync: assert property (p_sync) else $error("sync flag rose without sync byte");
   property p_unsync;
      tk && !o_synced && i_byte != 8'ha2 |=> !o_action_valid && !o_mem_wr && !o_mem_rd && $stable(o_radio_state);
   endproperty
   a_unsync: assert property (p_unsync) else $error("byte acted on before sync");
   property p_off;
      tc && o_synced && i_byte == 8'hb0 |=> o_radio_state == off_state;
   endproperty
   a_off: assert property (p_off) else $error("off code did not reach off state");
   property p_rx;
      tc && o_synced && i_byte == 8'hb2 |=> o_radio_state == receive_state;
   endproperty
   a_rx: assert property (p_rx) else $error("receive code did not reach receive state");
   property p_tx;
      tc && o_synced && i_byte == 8'hb5 |=> o_radio_state == transmit_state;
   endproperty
   a_tx: assert property (p_tx) else $error("transmit code did not reach transmit state");
   property p_sleep;
      tc && o_synced && i_byte == 8'hba |=> o_radio_state == sleep_state;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep code did not reach sleep state");
   property p_config;
      tc && o_synced && i_byte == 8'hbb |=> o_action_valid && o_action == act_apply_config;
   endproperty
   a_config: assert property (p_config) else $error("config code gave no config action");
   property p_reset;
      tc && o_synced && i_byte == 8'hc8 |=> o_core_reset && !o_synced && o_radio_state == sleep_state;
   endproperty
   a_reset: assert property (p_reset) else $error("full reset did not leave device asleep");
   property p_core;
      tc && o_synced && i_byte == 8'hc7 |=> o_core_reset && o_action_valid && o_action == act_load_done;
   endproperty
   a_core: assert property (p_core) else $error("load done gave no controller reset");
   property p_mod;
      tk && i_module == 2'h0 && (i_byte == 8'hd0 || i_byte == 8'hd1 || i_byte == 8'hd2) |=> !o_action_valid;
   endproperty
   a_mod: assert property (p_mod) else $error("module code acted with no module loaded");
   property p_img;
      tk && i_byte == 8'hbd && i_module != 2'h1 |=> !o_action_valid;
   endproperty
   a_img: assert property (p_img) else $error("image calibration ran without its module");
   property p_rd;
      o_mem_rd |=> s_ret;
   endproperty
   a_rd: assert property (p_rd) else $error("read fetch returned no matching byte");
endmodule

bind rscd_decoder rscd_checker i_chk (.i_ref_clk, .i_rst, .i_frame, .i_byte_valid, .i_byte, .i_module,
   .i_rd_data, .o_radio_state, .o_action, .o_action_valid, .o_synced, .o_core_reset, .o_mem_wr, .o_mem_rd,
   .o_tx_byte, .o_tx_byte_valid);

// ---- dv/rscd_host_model.sv ----
// Purpose: Host processor model acting as master of the command port.
// Assumes: Bytes are already assembled; one strobe marks each byte.
// Notes:   Between strobes the byte lines show the inverse of the last byte.
`timescale 1ns/1ps
module rscd_host_model (
   input  wire logic i_ref_clk,
   output logic      o_frame,
   output logic      o_byte_valid,
   output logic [7:0] o_byte
);
   initial begin
      o_frame = 1'b0;
      o_byte_valid = 1'b0;
      o_byte = 8'h00;
   end
   task automatic open_frame();
      @(posedge i_ref_clk);
      o_frame <= 1'b1;
   endtask
   // Returning to the command phase needs the frame low for an edge.
   task automatic close_frame();
      @(posedge i_ref_clk);
      o_frame <= 1'b0;
   endtask
   // Three idle edges ahead of each byte leave room for read fetches.
   task automatic put(input logic [7:0] b);
      repeat (3) @(posedge i_ref_clk);
      o_byte_valid <= 1'b1;
      o_byte <= b;
      @(posedge i_ref_clk);
      o_byte_valid <= 1'b0;
      o_byte <= ~b;
      #1;
   endtask
endmodule

// ---- dv/test_radio_spi_command_decoder.sv ----
// Purpose: Self-checking bench for the radio SPI command decoder.
// Assumes: The host model spaces bytes three idle edges apart.
// Notes:   Each scenario task judges the ports before it returns.
`timescale 1ns/1ps
module test_radio_spi_command_decoder;
   import rscd_pkg::*;
   logic              i_ref_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic [1:0]        i_module = 2'h0;
   logic [7:0]        i_rd_data = 8'h00;
   wire               frame;
   wire               bv;
   wire [7:0]         bt;
   rscd_radio_state_t st;
   rscd_action_t      act;
   logic              av, syn, crst, wr, rd, txv;
   logic [10:0]       addr;
   logic [2:0]        rgn;
   logic [7:0]        wd, txb;
   int                n_fail = 0;
   int                checks_done = 0;
   always #2.5 i_ref_clk = ~i_ref_clk;
   rscd_host_model i_host (.i_ref_clk(i_ref_clk), .o_frame(frame), .o_byte_valid(bv), .o_byte(bt));
   rscd_decoder i_rscd_decoder (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_frame(frame), .i_byte_valid(bv),
      .i_byte(bt), .i_module(i_module), .i_rd_data(i_rd_data), .o_radio_state(st), .o_action(act),
      .o_action_valid(av), .o_synced(syn), .o_core_reset(crst), .o_mem_addr(addr), .o_mem_region(rgn),
      .o_mem_wr(wr), .o_mem_wr_data(wd), .o_mem_rd(rd), .o_tx_byte(txb), .o_tx_byte_valid(txv));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic t_sync();
      i_host.open_frame();
      i_host.put(8'hb1);
      chk("state before sync", sleep_state, st);
      chk("action before sync", 1'b0, av);
      i_host.put(8'ha2);
      chk("synced", 1'b1, syn);
   endtask
   task automatic t_states();
      logic [7:0]        c[5] = '{8'hb0, 8'hb1, 8'hb2, 8'hb5, 8'hba};
      rscd_radio_state_t e[5] = '{off_state, idle_state, receive_state, transmit_state, sleep_state};
      foreach (c[k]) begin
         i_host.put(c[k]);
         chk("radio state", e[k], st);
      end
   endtask
   task automatic t_actions();
      logic [1:0]   m[15] = '{0, 0, 0, 0, 0, 1, 2, 2, 2, 3, 3, 3, 0, 0, 0};
      logic [7:0]   c[15] = '{8'hbb, 8'hbc, 8'hbe, 8'hbf, 8'hbd, 8'hbd, 8'hd0, 8'hd1, 8'hd2, 8'hd1, 8'hd0,
                              8'hd2, 8'hd0, 8'h55, 8'hff};
      rscd_action_t e[15] = '{act_apply_config, act_signal_strength, act_if_filter_cal, act_load_init,
                              act_none, act_image_cal, act_cipher_encrypt, act_cipher_decrypt_setup,
                              act_cipher_decrypt, act_fec_encode_setup, act_fec_encode, act_fec_decode,
                              act_none, act_none, act_none};
      foreach (c[k]) begin
         @(posedge i_ref_clk);
         i_module <= m[k];
         i_host.put(c[k]);
         chk("action strobe", e[k] != act_none, av);
         if (e[k] != act_none) chk("action", e[k], act);
         chk("no write", 1'b0, wr);
         chk("state kept", sleep_state, st);
      end
      i_host.put(8'hc7);
      chk("core reset", 1'b1, crst);
   endtask
   task automatic t_full_reset();
      i_host.put(8'hb1);
      i_host.put(8'hc8);
      chk("reset pulse", 1'b1, crst);
      chk("state after reset", sleep_state, st);
      chk("sync after reset", 1'b0, syn);
      i_host.put(8'ha2);
      i_host.close_frame();
   endtask
   task automatic t_write(input logic [7:0] c, input logic [7:0] a, input logic [10:0] base);
      logic [7:0] d[2] = '{8'h3c, 8'hc3};
      i_host.open_frame();
      i_host.put(c);
      i_host.put(a);
      foreach (d[k]) begin
         i_host.put(d[k]);
         chk("write strobe", 1'b1, wr);
         chk("write address", base + 11'(k), addr);
         chk("write data", d[k], wd);
         chk("write region", c[2:0], rgn);
      end
      i_host.close_frame();
   endtask
   task automatic t_read(input logic [7:0] c, input logic [7:0] a, input logic [10:0] base);
      int n;
      @(posedge i_ref_clk);
      i_rd_data <= a ^ 8'h6c;
      i_host.open_frame();
      i_host.put(c);
      i_host.put(a);
      chk("read strobe", 1'b1, rd);
      chk("read address", base, addr);
      for (n = 0; n < 4 && txv !== 1'b1; n++) begin
         @(posedge i_ref_clk);
         #1;
      end
      chk("read return", 1'b1, txv);
      chk("read byte", a ^ 8'h6c, txb);
      @(posedge i_ref_clk);
      i_rd_data <= a ^ 8'h93;
      i_host.put(8'hff);
      chk("filler write", 1'b0, wr);
      @(posedge i_ref_clk);
      #1;
      chk("filler address", base + 11'h001, addr);
      chk("filler fetch", 1'b1, rd);
      @(posedge i_ref_clk);
      #1;
      chk("filler return", 1'b1, txv);
      chk("filler byte", a ^ 8'h93, txb);
      i_host.close_frame();
   endtask
   task automatic t_scattered();
      logic [7:0] a[2] = '{8'h05, 8'h09};
      logic [7:0] d[2] = '{8'ha1, 8'hb2};
      i_host.open_frame();
      i_host.put(8'h08);
      foreach (a[k]) begin
         i_host.put(a[k]);
         i_host.put(d[k]);
         chk("scattered strobe", 1'b1, wr);
         chk("scattered address", {3'h0, a[k]}, addr);
         chk("scattered data", d[k], wd);
      end
      i_host.close_frame();
      i_host.open_frame();
      i_host.put(8'h2b);
      i_host.put(8'h40);
      chk("scattered read", 1'b1, rd);
      chk("scattered read address", 11'h340, addr);
      i_host.close_frame();
   endtask
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_sync();
      t_states();
      t_actions();
      t_full_reset();
      t_write(8'h18, 8'h7d, 11'h07d);
      t_write(8'h19, 8'h2a, 11'h12a);
      t_write(8'h1b, 8'h10, 11'h310);
      t_write(8'h1e, 8'h00, 11'h600);
      t_read(8'h38, 8'h05, 11'h005);
      t_read(8'h39, 8'h22, 11'h122);
      t_read(8'h3b, 8'h12, 11'h312);
      t_scattered();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      n_fail++;
      $display("[FAIL] run length expected below 20000 seen 20000");
      print_verdict();
   end
endmodule
